/* uart_hold_asserts.sv */
// Purpose: Port checks for the UART holding, interrupt and DMA logic
// Assumes: i_clk_en held high by the bench
// Notes:   Bound to the design top after the module
`timescale 1ns/1ps

module uart_hold_asserts (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic i_rxd,
  input wire logic i_bus_mode68,
  input wire logic o_data_oe,
  input wire logic o_txd,
  input wire logic o_irq,
  input wire logic o_irq_wor_oe,
  input wire logic o_tx_dma_request_n,
  input wire logic o_rx_dma_request_n
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the last active bus strobe, saturating
  logic [3:0] bus_age_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || bus_age_r == 4'hf) bus_age_r <= 4'hf;
    else bus_age_r <= bus_age_r + 4'h1;
    if (!i_cs_n && !(i_rd_n && i_wr_n)) bus_age_r <= 4'h0;
  end

  // Cycles since the serial input was last seen low, saturating
  logic [9:0] rxd_age_r;
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rxd_age_r <= 10'h3ff;
    end else if (!i_rxd) begin
      rxd_age_r <= 10'h000;
    end else if (rxd_age_r != 10'h3ff) begin
      rxd_age_r <= rxd_age_r + 10'h001;
    end
  end

  sequence s_line_recent;
    rxd_age_r < 10'h300;
  endsequence
  sequence s_start_bit;
    !o_txd [*8];
  endsequence
  sequence s_bus_recent;
    bus_age_r < 4'hc;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_reset_idle: assert property (
    $fell(i_reset) |-> o_txd && !o_tx_dma_request_n && o_rx_dma_request_n)
    else $error("outputs not idle after reset");
  a_irq_mode16: assert property (o_irq |-> !i_bus_mode68)
    else $error("irq output active in 68 mode");
  a_irq_mode68: assert property (o_irq_wor_oe |-> i_bus_mode68)
    else $error("shared irq driven in 16 mode");
  a_irq_single: assert property (!(o_irq && o_irq_wor_oe))
    else $error("both irq outputs active");
  a_read_drive: assert property ($rose(o_data_oe) |-> !i_cs_n && !i_rd_n)
    else $error("data driven without read");
  a_rx_arrive: assert property ($fell(o_rx_dma_request_n) |-> s_line_recent)
    else $error("rx request without character");
  a_rx_release: assert property ($rose(o_rx_dma_request_n) |-> s_bus_recent)
    else $error("rx request released without read");
  a_tx_load: assert property ($rose(o_tx_dma_request_n) |-> s_bus_recent)
    else $error("tx request rose without write");
  a_start_bit: assert property ($fell(o_txd) |-> s_start_bit)
    else $error("transmit start bit too short");
endmodule

bind uart_holding_irq_dma_logic uart_hold_asserts u_chk (.i_ref_clk, .i_reset, .i_cs_n,
  .i_rd_n, .i_wr_n, .i_rxd, .i_bus_mode68, .o_data_oe, .o_txd, .o_irq, .o_irq_wor_oe,
  .o_tx_dma_request_n, .o_rx_dma_request_n);

/* uart_hold_pkg.sv */
// Purpose: Shared constants for the UART holding, interrupt and DMA logic
// Assumes: One channel, 16x bit-rate tick supplied by the baud generator
// Notes:   Register addresses are the three address pins of the byte bus
package uart_hold_pkg;

  // Register addresses (A2..A0)
  localparam logic [2:0] ADDR_HOLD  = 3'h0;
  localparam logic [2:0] ADDR_MASK  = 3'h1;
  localparam logic [2:0] ADDR_FIFO  = 3'h2;
  localparam logic [2:0] ADDR_LCTRL = 3'h3;
  localparam logic [2:0] ADDR_LSTAT = 3'h5;

  // Field positions
  localparam int MASK_RX     = 0;
  localparam int MASK_TX     = 1;
  localparam int MASK_LS     = 2;
  localparam int MASK_MS     = 3;
  localparam int FCR_EN      = 0;
  localparam int FCR_RXRST   = 1;
  localparam int FCR_TXRST   = 2;
  localparam int FCR_DMA     = 3;
  localparam int FCR_TRIG_LO = 6;
  localparam int FCR_TRIG_HI = 7;
  localparam int LCR_DLAB    = 7;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [14:0] SYNC_IDLE = 15'h7800;

  // FIFO geometry
  localparam logic [4:0] DEPTH_FIFO = 5'h10;
  localparam logic [4:0] DEPTH_ONE  = 5'h01;
  localparam logic [4:0] CNT_ZERO   = 5'h00;
  localparam logic [3:0] PTR_ONE    = 4'h1;
  localparam logic [4:0] CNT_ONE    = 5'h01;

  // Receive trigger levels selected by the two trigger bits
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;

  // Bit timing in 16x ticks
  localparam logic [3:0] TICK_ZERO = 4'h0;
  localparam logic [3:0] TICK_ONE  = 4'h1;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] START_MID = 4'h7;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_ONE   = 3'h1;

  // Interrupt identification codes, bit 0 low means pending
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_LS   = 4'h6;
  localparam logic [3:0] ID_RX   = 4'h4;
  localparam logic [3:0] ID_TX   = 4'h2;
  localparam logic [3:0] ID_MS   = 4'h0;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b11,
    RX_STOP  = 2'b10
  } rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b11,
    TX_STOP  = 2'b10
  } tx_state_t;

endpackage

/* uart_holding_irq_dma_logic.sv */
// Purpose: UART holding registers, start-bit check, interrupt mask and DMA requests
// Assumes: i_tick16 is a one-cycle enable at sixteen times the bit rate
// Notes:   8 data bits, 1 stop bit, no parity on the line
//
// Contract
// - Holding write captures the data byte when holding register or FIFO has room.
// - Holding-empty flag sets when transmitter empties or byte moves to shift register.
// - Reading the receive holding register returns oldest byte and pops it.
// - Start edge starts 16x count; line sampled at mid start, high means discard.
// - Mask bit 3 enables the modem status interrupt, default off.
// - Mask bit 2 enables the receive line status interrupt, default off.
// - Mask bit 1 raises transmit interrupt while holding register is empty.
// - Mask bit 0 raises receive interrupt at trigger level, clears below it.
// - Interrupt on own output in 16 mode, wire-OR output in 68 mode.
// - Identification shows receive trigger while reached, clears below trigger.
// - Data ready sets when a character enters the FIFO, clears when empty.
// - FIFO on with mask bits clear gives polled mode through status bits.
// - Status bits 4, 3 and 1 report receive errors, bit 2 reads 0, bit 7 flags errored FIFO data.
// - Status bit 5 means transmit FIFO empty, bit 6 also shifter empty.
// - Mode 0: tx request low when holding empty, rx request low with data.
// - Mode 1: transmit interrupt set while any transmit FIFO location is free.
// - Mode 1: receive interrupt at trigger, rx request low once trigger level is reached.
// - Trigger level selected by the two upper FIFO control bits.
// - Mode 1: rx request returns high only when receive FIFO is empty.
// - Mode 1: tx request high only when transmit FIFO is full.
// - Holding and mask registers reachable only while divisor latch bit is 0.
`timescale 1ns/1ps

module uart_holding_irq_dma_logic
  import uart_hold_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_reset,
  input  wire logic       i_clk_en,
  input  wire logic       i_tick16,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_data,
  input  wire logic       i_rxd,
  input  wire logic       i_modem_change,
  input  wire logic       i_bus_mode68,
  output logic      [7:0] o_data,
  output logic            o_data_oe,
  output logic            o_txd,
  output logic            o_irq,
  output logic            o_irq_wor_oe,
  output logic            o_tx_dma_request_n,
  output logic            o_rx_dma_request_n
);

  function automatic logic [3:0] ptr_inc(input logic [3:0] p);
    ptr_inc = p + PTR_ONE;
  endfunction

  function automatic logic [4:0] trig_level(input logic [1:0] sel);
    case (sel)
      2'b00:   trig_level = TRIG_L0;
      2'b01:   trig_level = TRIG_L1;
      2'b10:   trig_level = TRIG_L2;
      default: trig_level = TRIG_L3;
    endcase
  endfunction

  logic [14:0] sync1_r;
  logic [14:0] sync2_r;
  logic        rd_act;
  logic        wr_act;
  logic        rd_prev_r;
  logic        wr_prev_r;
  logic        rd_end;
  logic        wr_end;
  logic        rxd_s;
  logic        rxd_prev_r;
  logic [2:0]  bus_addr_r;
  logic [7:0]  bus_data_r;
  logic [7:0]  interrupt_mask_reg_r;
  logic [7:0]  fifo_control_reg_r;
  logic [7:0]  line_control_reg_r;
  logic        dlab;
  logic        fifo_en;
  logic        dma_mode1;
  logic        fcr_wr;
  logic        tx_clr;
  logic        rx_clr;
  logic        thr_wr;
  logic        rhr_rd;
  logic        lsr_rd;
  logic [7:0]  tx_mem [16];
  logic [3:0]  tx_wp_r;
  logic [3:0]  tx_rp_r;
  logic [4:0]  tx_cnt_r;
  logic [4:0]  cap;
  logic        tx_space;
  logic        tx_load;
  logic        thr_empty;
  logic        tx_all_empty;
  tx_state_t   tx_st_r;
  logic [3:0]  tx_tick_r;
  logic [2:0]  tx_bit_r;
  logic [7:0]  transmit_shift_reg_r;
  logic [9:0]  rx_mem [16];
  logic [3:0]  rx_wp_r;
  logic [3:0]  rx_rp_r;
  logic [4:0]  rx_cnt_r;
  logic [4:0]  rx_err_cnt_r;
  logic        rx_push;
  logic        rx_pop;
  logic        rx_full;
  rx_state_t   rx_st_r;
  logic [3:0]  rx_tick_r;
  logic [2:0]  rx_bit_r;
  logic [7:0]  rx_shift_r;
  logic        rx_done;
  logic        rx_fe;
  logic        rx_be;
  logic        overrun_r;
  logic        framing_r;
  logic        break_r;
  logic        rx_trig;
  logic        rx_hold_r;
  logic        pend_ls;
  logic        pend_rx;
  logic        pend_tx;
  logic        pend_ms;
  logic [3:0]  int_id;
  logic [7:0]  interrupt_ident_reg;
  logic [7:0]  line_status_reg;
  logic [7:0]  rd_val;
  logic        irq_r;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus strobes

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync1_r <= SYNC_IDLE;
      sync2_r <= SYNC_IDLE;
    end else if (i_clk_en) begin
      sync1_r <= {i_cs_n, i_rd_n, i_wr_n, i_rxd, i_addr, i_data};
      sync2_r <= sync1_r;
    end
  end

  assign rd_act = ~sync2_r[14] & ~sync2_r[13];
  assign wr_act = ~sync2_r[14] & ~sync2_r[12];
  assign rxd_s  = sync2_r[11];
  assign rd_end = rd_prev_r & ~rd_act;
  assign wr_end = wr_prev_r & ~wr_act;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rd_prev_r  <= 1'b0;
      wr_prev_r  <= 1'b0;
      rxd_prev_r <= 1'b1;
      bus_addr_r <= ADDR_HOLD;
      bus_data_r <= RST_BYTE;
    end else if (i_clk_en) begin
      rd_prev_r  <= rd_act;
      wr_prev_r  <= wr_act;
      rxd_prev_r <= rxd_s;
      if (rd_act || wr_act) begin
        bus_addr_r <= sync2_r[10:8];
        bus_data_r <= sync2_r[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  assign dlab      = line_control_reg_r[LCR_DLAB];
  assign fifo_en   = fifo_control_reg_r[FCR_EN];
  assign dma_mode1 = fifo_en & fifo_control_reg_r[FCR_DMA];
  assign fcr_wr    = wr_end && bus_addr_r == ADDR_FIFO;
  assign tx_clr    = fcr_wr && (bus_data_r[FCR_TXRST] || bus_data_r[FCR_EN] != fifo_en);
  assign rx_clr    = fcr_wr && (bus_data_r[FCR_RXRST] || bus_data_r[FCR_EN] != fifo_en);
  assign thr_wr    = wr_end && bus_addr_r == ADDR_HOLD && !dlab;
  assign rhr_rd    = rd_end && bus_addr_r == ADDR_HOLD && !dlab;
  assign lsr_rd    = rd_end && bus_addr_r == ADDR_LSTAT;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      interrupt_mask_reg_r <= RST_BYTE;
      fifo_control_reg_r   <= RST_BYTE;
      line_control_reg_r   <= RST_BYTE;
    end else if (i_clk_en && wr_end) begin
      if (bus_addr_r == ADDR_MASK && !dlab) begin
        interrupt_mask_reg_r <= {4'h0, bus_data_r[3:0]};
      end
      if (bus_addr_r == ADDR_FIFO) begin
        fifo_control_reg_r <= {bus_data_r[FCR_TRIG_HI:FCR_TRIG_LO], 2'b00,
                               bus_data_r[FCR_DMA], 2'b00, bus_data_r[FCR_EN]};
      end
      if (bus_addr_r == ADDR_LCTRL) begin
        line_control_reg_r <= bus_data_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit holding FIFO

  assign cap          = fifo_en ? DEPTH_FIFO : DEPTH_ONE;
  assign tx_space     = tx_cnt_r < cap;
  assign thr_empty    = tx_cnt_r == CNT_ZERO;
  assign tx_load      = tx_st_r == TX_IDLE && !thr_empty;
  assign tx_all_empty = thr_empty && tx_st_r == TX_IDLE;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tx_wp_r  <= 4'h0;
      tx_rp_r  <= 4'h0;
      tx_cnt_r <= CNT_ZERO;
    end else if (i_clk_en) begin
      if (tx_clr) begin
        tx_wp_r  <= 4'h0;
        tx_rp_r  <= 4'h0;
        tx_cnt_r <= CNT_ZERO;
      end else begin
        if (thr_wr && tx_space) begin
          tx_mem[tx_wp_r] <= bus_data_r;
          tx_wp_r         <= ptr_inc(tx_wp_r);
        end
        if (tx_load) begin
          tx_rp_r <= ptr_inc(tx_rp_r);
        end
        if ((thr_wr && tx_space) && !tx_load) begin
          tx_cnt_r <= tx_cnt_r + CNT_ONE;
        end else if (!(thr_wr && tx_space) && tx_load) begin
          tx_cnt_r <= tx_cnt_r - CNT_ONE;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit shift register

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      tx_st_r              <= TX_IDLE;
      tx_tick_r            <= TICK_ZERO;
      tx_bit_r             <= 3'h0;
      transmit_shift_reg_r <= RST_BYTE;
      o_txd                <= 1'b1;
    end else if (i_clk_en) begin
      case (tx_st_r)
        TX_IDLE: begin
          o_txd <= 1'b1;
          if (tx_load) begin
            transmit_shift_reg_r <= tx_mem[tx_rp_r];
            tx_tick_r            <= TICK_ZERO;
            tx_st_r              <= TX_START;
          end
        end
        TX_START: begin
          o_txd <= 1'b0;
          if (i_tick16) begin
            tx_tick_r <= tx_tick_r + TICK_ONE;
            if (tx_tick_r == TICK_LAST) begin
              tx_bit_r <= 3'h0;
              tx_st_r  <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          o_txd <= transmit_shift_reg_r[0];
          if (i_tick16) begin
            tx_tick_r <= tx_tick_r + TICK_ONE;
            if (tx_tick_r == TICK_LAST) begin
              transmit_shift_reg_r <= {1'b0, transmit_shift_reg_r[7:1]};
              tx_bit_r             <= tx_bit_r + BIT_ONE;
              if (tx_bit_r == BIT_LAST) begin
                tx_st_r <= TX_STOP;
              end
            end
          end
        end
        TX_STOP: begin
          o_txd <= 1'b1;
          if (i_tick16) begin
            tx_tick_r <= tx_tick_r + TICK_ONE;
            if (tx_tick_r == TICK_LAST) begin
              tx_st_r <= TX_IDLE;
            end
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive shift register with false start rejection

  assign rx_done = rx_st_r == RX_STOP && i_tick16 && rx_tick_r == TICK_LAST;
  assign rx_fe   = ~rxd_s;
  assign rx_be   = rx_fe && rx_shift_r == RST_BYTE;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rx_st_r    <= RX_IDLE;
      rx_tick_r  <= TICK_ZERO;
      rx_bit_r   <= 3'h0;
      rx_shift_r <= RST_BYTE;
    end else if (i_clk_en) begin
      case (rx_st_r)
        RX_IDLE: begin
          if (rxd_prev_r && !rxd_s) begin
            rx_tick_r <= TICK_ZERO;
            rx_st_r   <= RX_START;
          end
        end
        RX_START: begin
          if (i_tick16) begin
            rx_tick_r <= rx_tick_r + TICK_ONE;
            if (rx_tick_r == START_MID) begin
              rx_tick_r <= TICK_ZERO;
              rx_bit_r  <= 3'h0;
              rx_st_r   <= rxd_s ? RX_IDLE : RX_DATA;
            end
          end
        end
        RX_DATA: begin
          if (i_tick16) begin
            rx_tick_r <= rx_tick_r + TICK_ONE;
            if (rx_tick_r == TICK_LAST) begin
              rx_shift_r <= {rxd_s, rx_shift_r[7:1]};
              rx_bit_r   <= rx_bit_r + BIT_ONE;
              if (rx_bit_r == BIT_LAST) begin
                rx_st_r <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (i_tick16) begin
            rx_tick_r <= rx_tick_r + TICK_ONE;
            if (rx_tick_r == TICK_LAST) begin
              rx_st_r <= RX_IDLE;
            end
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO

  assign rx_full = rx_cnt_r >= cap;
  assign rx_push = rx_done && !rx_full;
  assign rx_pop  = rhr_rd && rx_cnt_r != CNT_ZERO;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rx_wp_r      <= 4'h0;
      rx_rp_r      <= 4'h0;
      rx_cnt_r     <= CNT_ZERO;
      rx_err_cnt_r <= CNT_ZERO;
    end else if (i_clk_en) begin
      if (rx_clr) begin
        rx_wp_r      <= 4'h0;
        rx_rp_r      <= 4'h0;
        rx_cnt_r     <= CNT_ZERO;
        rx_err_cnt_r <= CNT_ZERO;
      end else begin
        if (rx_push) begin
          rx_mem[rx_wp_r] <= {rx_be, rx_fe, rx_shift_r};
          rx_wp_r         <= ptr_inc(rx_wp_r);
        end
        if (rx_pop) begin
          rx_rp_r <= ptr_inc(rx_rp_r);
        end
        if (rx_push && !rx_pop) begin
          rx_cnt_r <= rx_cnt_r + CNT_ONE;
        end else if (!rx_push && rx_pop) begin
          rx_cnt_r <= rx_cnt_r - CNT_ONE;
        end
        if ((rx_push && rx_fe) && !(rx_pop && rx_mem[rx_rp_r][8])) begin
          rx_err_cnt_r <= rx_err_cnt_r + CNT_ONE;
        end else if (!(rx_push && rx_fe) && (rx_pop && rx_mem[rx_rp_r][8])) begin
          rx_err_cnt_r <= rx_err_cnt_r - CNT_ONE;
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      overrun_r <= 1'b0;
      framing_r <= 1'b0;
      break_r   <= 1'b0;
    end else if (i_clk_en) begin
      overrun_r <= (rx_done && rx_full) || (overrun_r && !lsr_rd);
      framing_r <= rx_push && rx_fe || (framing_r && !lsr_rd);
      break_r   <= rx_push && rx_be || (break_r && !lsr_rd);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, identification and read data

  assign rx_trig = fifo_en ? rx_cnt_r >= trig_level(fifo_control_reg_r[FCR_TRIG_HI:FCR_TRIG_LO])
                           : rx_cnt_r != CNT_ZERO;
  assign pend_ls = interrupt_mask_reg_r[MASK_LS] && (overrun_r || framing_r || break_r);
  assign pend_rx = interrupt_mask_reg_r[MASK_RX] && rx_trig;
  assign pend_tx = interrupt_mask_reg_r[MASK_TX] && (dma_mode1 ? tx_space : thr_empty);
  assign pend_ms = interrupt_mask_reg_r[MASK_MS] && i_modem_change;

  always_comb begin
    if (pend_ls) begin
      int_id = ID_LS;
    end else if (pend_rx) begin
      int_id = ID_RX;
    end else if (pend_tx) begin
      int_id = ID_TX;
    end else if (pend_ms) begin
      int_id = ID_MS;
    end else begin
      int_id = ID_NONE;
    end
  end

  assign interrupt_ident_reg = {fifo_en, fifo_en, 2'b00, int_id};
  assign line_status_reg = {rx_err_cnt_r != CNT_ZERO, tx_all_empty, thr_empty,
                            break_r, framing_r, 1'b0, overrun_r, rx_cnt_r != CNT_ZERO};

  always_comb begin
    case (bus_addr_r)
      ADDR_HOLD:  rd_val = dlab ? RST_BYTE : rx_mem[rx_rp_r][7:0];
      ADDR_MASK:  rd_val = dlab ? RST_BYTE : interrupt_mask_reg_r;
      ADDR_FIFO:  rd_val = interrupt_ident_reg;
      ADDR_LCTRL: rd_val = line_control_reg_r;
      ADDR_LSTAT: rd_val = line_status_reg;
      default:    rd_val = RST_BYTE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_data    <= RST_BYTE;
      o_data_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_data    <= rd_val;
      o_data_oe <= rd_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output and DMA requests

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_r <= 1'b0;
    end else if (i_clk_en) begin
      irq_r <= pend_ls || pend_rx || pend_tx || pend_ms;
    end
  end

  assign o_irq        = irq_r && !i_bus_mode68;
  assign o_irq_wor_oe = irq_r && i_bus_mode68;

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rx_hold_r <= 1'b0;
    end else if (i_clk_en) begin
      if (rx_trig) begin
        rx_hold_r <= 1'b1;
      end else if (rx_cnt_r == CNT_ZERO) begin
        rx_hold_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_tx_dma_request_n <= 1'b0;
      o_rx_dma_request_n <= 1'b1;
    end else if (i_clk_en) begin
      if (dma_mode1) begin
        o_tx_dma_request_n <= !tx_space;
        o_rx_dma_request_n <= !(rx_hold_r && rx_cnt_r != CNT_ZERO);
      end else begin
        o_tx_dma_request_n <= !thr_empty;
        o_rx_dma_request_n <= rx_cnt_r == CNT_ZERO;
      end
    end
  end

endmodule

/* uart_holding_irq_dma_logic_test.sv */
// Purpose: Self-checking bench for the UART holding logic
// Assumes: One tick every four clocks
// Notes:   Queue model of the receive FIFO
`timescale 1ns/1ps

module uart_holding_irq_dma_logic_test;
  import uart_hold_pkg::*;
  logic       i_ref_clk = 1'b0;
  logic       i_reset   = 1'b1;
  logic       i_tick16  = 1'b0;
  logic       i_cs_n    = 1'b1;
  logic       i_rd_n    = 1'b1;
  logic       i_wr_n    = 1'b1;
  logic [2:0] i_addr    = 3'h0;
  logic [7:0] i_data    = 8'h00;
  logic       i_modem_change = 1'b0;
  logic       i_bus_mode68   = 1'b0;
  logic       rxd, o_data_oe, o_txd, o_irq, o_irq_wor_oe, tx_n, rx_n, oe;
  logic [7:0] o_data, q, b;
  logic [7:0] mq[$];
  int         n_errors, num_checks, tcnt;

  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(negedge i_ref_clk) begin
    tcnt <= (tcnt + 1) % 4;
    i_tick16 <= (tcnt == 3);
  end

  uart_holding_irq_dma_logic u_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_clk_en(1'b1),
    .i_tick16(i_tick16), .i_cs_n(i_cs_n), .i_rd_n(i_rd_n), .i_wr_n(i_wr_n), .i_addr(i_addr),
    .i_data(i_data), .i_rxd(rxd), .i_modem_change(i_modem_change),
    .i_bus_mode68(i_bus_mode68), .o_data(o_data), .o_data_oe(o_data_oe), .o_txd(o_txd),
    .o_irq(o_irq), .o_irq_wor_oe(o_irq_wor_oe), .o_tx_dma_request_n(tx_n),
    .o_rx_dma_request_n(rx_n));
  uart_line_peer u_peer (.i_ref_clk(i_ref_clk), .i_tick16(i_tick16), .i_txd(o_txd),
    .o_rxd(rxd), .o_got());

  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: byte %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk1(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %0t: flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic bus(input logic rd, input logic [2:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_cs_n = 1'b0;
    i_addr = a;
    i_data = d;
    i_rd_n = !rd;
    i_wr_n = rd;
    repeat (6) @(negedge i_ref_clk);
    q = o_data;
    oe = o_data_oe;
    i_cs_n = 1'b1;
    i_rd_n = 1'b1;
    i_wr_n = 1'b1;
    repeat (5) @(negedge i_ref_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    bus(1'b1, a, 8'h00);
    chk1(oe, 1'b1);
    chk8(q, e);
  endtask

  task automatic wait_lsr(input logic [7:0] m);
    int k;
    k = 0;
    bus(1'b1, ADDR_LSTAT, 8'h00);
    while ((q & m) !== m && k < 2000) begin
      bus(1'b1, ADDR_LSTAT, 8'h00);
      k++;
    end
    if (k == 2000) begin
      n_errors++;
      final_report();
    end
  endtask

  task automatic rxq(input logic [7:0] d);
    mq.push_back(d);
    u_peer.send(d, 1'b1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(5));
    repeat (3) @(negedge i_ref_clk);
    i_reset = 1'b0;
    rd(ADDR_MASK, RST_BYTE);
    rd(ADDR_LSTAT, 8'h60);
    rd(ADDR_FIFO, 8'h01);
    chk1(tx_n, 1'b0);
    chk1(rx_n, 1'b1);
    $display("test reset done");
    wr(ADDR_MASK, 8'h0f);
    rd(ADDR_MASK, 8'h0f);
    chk1(o_irq, 1'b1);
    wr(ADDR_LCTRL, 8'h80);
    wr(ADDR_MASK, 8'h00);
    rd(ADDR_MASK, 8'h00);
    wr(ADDR_LCTRL, 8'h00);
    rd(ADDR_MASK, 8'h0f);
    wr(ADDR_MASK, 8'h00);
    chk1(o_irq, 1'b0);
    $display("test mask done");
    b = 8'($urandom);
    wait_lsr(8'h20);
    wr(ADDR_HOLD, b);
    wait_lsr(8'h40);
    chk8(u_peer.o_got, b);
    rd(ADDR_LSTAT, 8'h60);
    $display("test transmit done");
    wr(ADDR_FIFO, 8'h41);
    wr(ADDR_MASK, 8'h01);
    u_peer.glitch();
    rd(ADDR_LSTAT, 8'h60);
    for (int i = 0; i < 4; i++) begin
      rxq(8'($urandom));
      chk1(o_irq, mq.size() >= 4);
      chk1(rx_n, 1'b0);
    end
    rd(ADDR_FIFO, 8'hc4);
    rd(ADDR_LSTAT, 8'h61);
    while (mq.size() > 0) begin
      rd(ADDR_HOLD, mq.pop_front());
      chk1(o_irq, mq.size() >= 4);
    end
    rd(ADDR_LSTAT, 8'h60);
    b = 8'($urandom) | 8'h01;
    u_peer.send(b, 1'b0);
    rd(ADDR_LSTAT, 8'he9);
    rd(ADDR_HOLD, b);
    rd(ADDR_LSTAT, 8'h60);
    $display("test receive done");
    wr(ADDR_MASK, 8'h08);
    i_modem_change = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    chk1(o_irq, 1'b1);
    i_bus_mode68 = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    chk1(o_irq, 1'b0);
    chk1(o_irq_wor_oe, 1'b1);
    i_modem_change = 1'b0;
    i_bus_mode68 = 1'b0;
    wr(ADDR_MASK, 8'h00);
    $display("test modem done");
    wr(ADDR_FIFO, 8'h4b);
    repeat (17) wr(ADDR_HOLD, 8'($urandom));
    chk1(tx_n, 1'b1);
    wr(ADDR_MASK, 8'h02);
    chk1(o_irq, 1'b0);
    wait_lsr(8'h40);
    chk1(o_irq, 1'b1);
    chk1(tx_n, 1'b0);
    wr(ADDR_MASK, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rxq(8'($urandom));
      chk1(rx_n, mq.size() < 4);
    end
    rd(ADDR_LSTAT, 8'h61);
    rd(ADDR_HOLD, mq.pop_front());
    chk1(rx_n, 1'b0);
    while (mq.size() > 0) rd(ADDR_HOLD, mq.pop_front());
    chk1(rx_n, 1'b1);
    $display("test dma done");
    final_report();
  end
endmodule

/* uart_line_peer.sv */
// Purpose: Serial line peer, 8N1 at sixteen ticks per bit
// Assumes: Tick is stable at rising edges
// Notes:   Drives at falling edges, line idles high
`timescale 1ns/1ps

module uart_line_peer (
  input  wire logic       i_ref_clk,
  input  wire logic       i_tick16,
  input  wire logic       i_txd,
  output logic            o_rxd,
  output logic      [7:0] o_got
);
  initial o_rxd = 1'b1;

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge i_ref_clk);
      while (!i_tick16) @(posedge i_ref_clk);
    end
    @(negedge i_ref_clk);
  endtask

  task automatic send(input logic [7:0] b, input logic stop);
    o_rxd = 1'b0;
    ticks(16);
    for (int i = 0; i < 8; i++) begin
      o_rxd = b[i];
      ticks(16);
    end
    o_rxd = stop;
    ticks(16);
    o_rxd = 1'b1;
    ticks(32);
  endtask

  task automatic glitch();
    o_rxd = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    o_rxd = 1'b1;
    ticks(32);
  endtask

  initial forever begin
    logic [7:0] sh;
    @(negedge i_txd);
    ticks(8);
    for (int i = 0; i < 8; i++) begin
      ticks(16);
      sh[i] = i_txd;
    end
    o_got = sh;
  end
endmodule
